// ==== design/rfid_tx_defines.svh ====
// Register map, field positions, presets, command codes and timing counts of the transmit control block
`ifndef RFID_TX_DEFINES_SVH
`define RFID_TX_DEFINES_SVH
`define RFT_A_CHIP_CTRL 8'h00
`define RFT_A_PROTOCOL 8'h01
`define RFT_A_TX_OPT 8'h02
`define RFT_A_RX_OPT 8'h03
`define RFT_A_CAL_LO 8'h04
`define RFT_A_CAL_HI 8'h05
`define RFT_A_SLOT 8'h06
`define RFT_A_IRQ 8'h0c
`define RFT_A_STATUS 8'h0e
`define RFT_A_MODSET 8'h15
`define RFT_A_LEN1 8'h1d
`define RFT_A_LEN2 8'h1e
`define RFT_A_FIFO 8'h1f
`define RFT_A_CMD 8'h20
`define RFT_A_HANDLE_HI 8'h21
`define RFT_A_HANDLE_LO 8'h22
`define RFT_CC_CARRIER 0
`define RFT_CC_RECEIVER 1
`define RFT_CC_GAIN_CTRL 2
`define RFT_CC_GAIN_LEVEL 3
`define RFT_CC_DAC 4
`define RFT_CC_DIRECT 5
`define RFT_CC_STANDBY 6
`define RFT_PS_SEL_LO 2
`define RFT_PS_SEL_HI 5
`define RFT_PS_CRC_SKIP 7
`define RFT_RX_DR 2
`define RFT_RX_TREXT 0
`define RFT_IRQ_TX_END 7
`define RFT_IRQ_FIFO_LOW 5
`define RFT_ST_SETTLED 0
`define RFT_ST_BUSY 1
`define RFT_RST_CHIP_CTRL 8'h00
`define RFT_RST_MODSET 8'h00
`define RFT_RST_SLOT 8'h00
`define RFT_PRE_PROTOCOL 8'h02
`define RFT_PRE_TX_OPT 8'hf0
`define RFT_PRE_RX_OPT 8'h61
`define RFT_PRE_CALIBRATION_HIGH 12'h535
`define RFT_CMD_TX_NOCRC 8'h90
`define RFT_CMD_TX_CRC 8'h91
`define RFT_CMD_DLY_NOCRC 8'h92
`define RFT_CMD_DLY_CRC 8'h93
`define RFT_CMD_QUERY 8'h98
`define RFT_CMD_QUERYREP 8'h99
`define RFT_CMD_QUERYADJ 8'h9a
`define RFT_CMD_ACK 8'h9b
`define RFT_CMD_NAK 8'h9c
`define RFT_CMD_REQRN 8'h9d
`define RFT_FIFO_DEPTH 5'd24
`define RFT_FIFO_LOW_MARK 5'd3
`define RFT_CLK_MHZ 40
`define RFT_TARI_LONG_NS 25000
`define RFT_TARI_LONG_CYC ((`RFT_TARI_LONG_NS * `RFT_CLK_MHZ) / 1000)
`define RFT_DELIM_NS 12500
`define RFT_DELIM_CYC ((`RFT_DELIM_NS * `RFT_CLK_MHZ) / 1000)
`define RFT_RAMP_100_US 100
`define RFT_RAMP_200_US 200
`define RFT_RAMP_400_US 400
`define RFT_RAMP_100_CYC (`RFT_RAMP_100_US * `RFT_CLK_MHZ)
`define RFT_RAMP_200_CYC (`RFT_RAMP_200_US * `RFT_CLK_MHZ)
`define RFT_RAMP_400_CYC (`RFT_RAMP_400_US * `RFT_CLK_MHZ)
`define RFT_SLOT_UNIT_US 1
`define RFT_SLOT_UNIT_CYC (`RFT_SLOT_UNIT_US * `RFT_CLK_MHZ)
`define RFT_CALIBRATION_HIGH_UNIT_CYC 4
`define RFT_CRC16_PRESET 16'hffff
`define RFT_CRC16_POLY 16'h1021
`define RFT_CRC5_PRESET 5'h09
`define RFT_CRC5_POLY 5'h09
`endif

// ==== design/rfid_tx_pkg.sv ====
// Types shared by the transmit control block
package rfid_tx_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_DELIM, ST_DATA0, ST_RTCAL, ST_CALIBRATION_HIGH, ST_PAYLOAD, ST_WAIT_DATA, ST_CRC, ST_TAIL
  } tx_state_e;
  typedef enum logic [1:0] {CRC_NONE, CRC_5, CRC_16} crc_kind_e;
endpackage : rfid_tx_pkg

// ==== design/rfid_reader_transmit_control.sv ====
// Chip control, option registers, transmit FIFO and forward-link framer of the reader
`timescale 1ns/10ps
`include "rfid_tx_defines.svh"
module rfid_reader_transmit_control #(
  parameter logic [14:0] RAMP_200_CYC = 15'(`RFT_RAMP_200_CYC),
  parameter logic [14:0] RAMP_400_CYC = 15'(`RFT_RAMP_400_CYC)
) (
  input wire logic i_clk, // 40 MHz clock
  input wire logic i_nrst, // Synchronous reset, active low
  input wire logic i_en, // Chip enable pin
  input wire logic [7:0] i_addr, // Register address
  input wire logic [7:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  input wire logic i_rx_end, // Pulse at end of a reception
  output logic [7:0] o_rdata, // Read data, cycle after read strobe
  output logic o_irq, // Interrupt request, high while a cause is pending
  output logic o_modulation, // Forward-link modulation, low during a pulse
  output logic o_tx_on, // Transmit section enabled
  output logic o_rx_section_on, // Receive section enabled by carrier
  output logic o_receiver_on, // Receiver operation enabled
  output logic o_gain_ctrl_on, // Automatic gain control enabled
  output logic o_gain_level_on, // Automatic gain leveling enabled
  output logic o_dac_on, // Converter enabled
  output logic o_direct_mode, // Direct data mode selected
  output logic o_standby, // Standby power mode requested
  output logic o_field_on, // Field present or ramping
  output logic o_carrier_settled, // Field ramp-up finished
  output logic o_rx_crc_skip, // Receiver passes CRC bytes as data
  output logic [1:0] o_rx_coding, // Receive coding selection
  output logic o_tx_busy // Framer is sending a frame
);
  logic [7:0] ctrl_q, prot_q, txo_q, rxo_q, cal_lo_q, cal_hi_q, slot_q, modset_q;
  logic [7:0] len1_q, len2_q, hnd_hi_q, hnd_lo_q, irq_q, rdata_q;
  logic en_q, en_rise, cmd_wr, gen2, fifo_wr, push, pop, sym_end, start_fifo, start_word;
  logic [7:0] fifo_mem [0:23];
  logic [4:0] wp_q, rp_q, cnt_q;
  logic [14:0] ramp_q, ramp_len;
  logic settled_q, field_q, irq_out_q, tx_mod_q, busy_q;
  rfid_tx_pkg::tx_state_e state_q;
  rfid_tx_pkg::crc_kind_e crc_kind_q, crc_cmd;
  logic src_word_q, query_q, armed_q, dly_wait_q, timer_run_q, next_bit, len_crc_q;
  logic [31:0] word_q, word_cmd;
  logic [5:0] word_len;
  logic [15:0] bits_left_q, fifo_bits, crc16_q;
  logic [4:0] crc5_q, crc_left_q;
  logic [7:0] byte_q;
  logic [3:0] byte_bits_q;
  logic [14:0] sym_q, timer_q;
  logic [11:0] d0_cyc, pw_cyc, d1_cyc, pw_base, d1_base;
  logic [12:0] rt_cyc;
  logic [14:0] tr_cyc;
  logic [1:0] tari_shift;
  logic cur_bit, have_bit, advance, crc_bit, low_phase;

  assign en_rise = i_en & ~en_q;
  assign cmd_wr = i_wr && (i_addr == `RFT_A_CMD);
  assign fifo_wr = i_wr && (i_addr == `RFT_A_FIFO);
  assign gen2 = ~prot_q[`RFT_PS_SEL_LO] & ~prot_q[`RFT_PS_SEL_HI];

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      en_q <= 1'b0;
    end else begin
      en_q <= i_en;
    end
  end

  // Option registers; the enable preset overrides a write in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_nrst || en_rise) begin
      prot_q <= `RFT_PRE_PROTOCOL;
      txo_q <= `RFT_PRE_TX_OPT;
      rxo_q <= `RFT_PRE_RX_OPT;
      cal_lo_q <= 8'(`RFT_PRE_CALIBRATION_HIGH & 12'h0ff);
      cal_hi_q <= {4'h0, 4'(`RFT_PRE_CALIBRATION_HIGH >> 8)};
    end else if (i_wr) begin
      unique case (i_addr)
        `RFT_A_PROTOCOL: prot_q <= i_wdata;
        `RFT_A_TX_OPT: txo_q <= i_wdata;
        `RFT_A_RX_OPT: rxo_q <= i_wdata;
        `RFT_A_CAL_LO: cal_lo_q <= i_wdata;
        `RFT_A_CAL_HI: cal_hi_q <= i_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ctrl_q <= `RFT_RST_CHIP_CTRL;
      slot_q <= `RFT_RST_SLOT;
      modset_q <= `RFT_RST_MODSET;
      len1_q <= 8'h00;
      len2_q <= 8'h00;
      hnd_hi_q <= 8'h00;
      hnd_lo_q <= 8'h00;
    end else if (i_wr) begin
      unique case (i_addr)
        `RFT_A_CHIP_CTRL: ctrl_q <= i_wdata;
        `RFT_A_SLOT: slot_q <= i_wdata;
        `RFT_A_MODSET: modset_q <= i_wdata;
        `RFT_A_LEN1: len1_q <= i_wdata;
        `RFT_A_LEN2: len2_q <= i_wdata;
        `RFT_A_HANDLE_HI: hnd_hi_q <= i_wdata;
        `RFT_A_HANDLE_LO: hnd_lo_q <= i_wdata;
        default: ;
      endcase
    end
  end

  // Forward-link timing from Tari, pulse width and data-one selections
  always_comb begin
    unique case (prot_q[1:0])
      2'b00: tari_shift = 2'd2;
      2'b01: tari_shift = 2'd1;
      default: tari_shift = 2'd0;
    endcase
    unique case (txo_q[7:6])
      2'b00: pw_base = 12'd270;
      2'b01: pw_base = 12'd350;
      2'b10: pw_base = 12'd440;
      2'b11: pw_base = 12'd500;
    endcase
    unique case (txo_q[5:4])
      2'b00: d1_base = 12'd1500;
      2'b01: d1_base = 12'd1660;
      2'b10: d1_base = 12'd1830;
      2'b11: d1_base = 12'd2000;
    endcase
    unique case (modset_q[1:0])
      2'b00: ramp_len = 15'(`RFT_TARI_LONG_CYC >> tari_shift);
      2'b01: ramp_len = 15'(`RFT_RAMP_100_CYC);
      2'b10: ramp_len = RAMP_200_CYC;
      2'b11: ramp_len = RAMP_400_CYC;
    endcase
  end
  assign d0_cyc = 12'(`RFT_TARI_LONG_CYC) >> tari_shift;
  assign pw_cyc = pw_base >> tari_shift;
  assign d1_cyc = d1_base >> tari_shift;
  assign rt_cyc = {1'b0, d0_cyc} + {1'b0, d1_cyc};
  assign tr_cyc = 15'({cal_hi_q[3:0], cal_lo_q} * 14'(`RFT_CALIBRATION_HIGH_UNIT_CYC));

  // Field ramp: counts up while the carrier is on, back down the same way when off
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ramp_q <= 15'h0000;
      settled_q <= 1'b0;
      field_q <= 1'b0;
    end else begin
      if (ctrl_q[`RFT_CC_CARRIER] && ramp_q < ramp_len) begin
        ramp_q <= ramp_q + 15'h0001;
      end else if (!ctrl_q[`RFT_CC_CARRIER] && ramp_q != 15'h0000) begin
        ramp_q <= ramp_q - 15'h0001;
      end
      settled_q <= ctrl_q[`RFT_CC_CARRIER] && ramp_q >= ramp_len;
      field_q <= ctrl_q[`RFT_CC_CARRIER] || ramp_q != 15'h0000;
    end
  end

  // Transmit FIFO; a transmit command flushes it
  assign push = fifo_wr && cnt_q != `RFT_FIFO_DEPTH;
  always_ff @(posedge i_clk) begin
    if (push) begin
      fifo_mem[wp_q] <= i_wdata;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_nrst || (cmd_wr && (i_wdata & 8'hfc) == `RFT_CMD_TX_NOCRC)) begin
      wp_q <= 5'h00;
      rp_q <= 5'h00;
      cnt_q <= 5'h00;
    end else begin
      if (push) begin
        wp_q <= (wp_q == `RFT_FIFO_DEPTH - 5'd1) ? 5'h00 : wp_q + 5'h01;
      end
      if (pop) begin
        rp_q <= (rp_q == `RFT_FIFO_DEPTH - 5'd1) ? 5'h00 : rp_q + 5'h01;
      end
      cnt_q <= cnt_q + {4'h0, push} - {4'h0, pop};
    end
  end

  // Built-in Gen2 command words, left aligned, with their CRC kind
  always_comb begin
    word_cmd = 32'h0000_0000;
    word_len = 6'd0;
    crc_cmd = rfid_tx_pkg::CRC_NONE;
    unique case (i_wdata)
      `RFT_CMD_QUERY: begin
        word_cmd = {4'b1000, rxo_q[`RFT_RX_DR], prot_q[4:3], rxo_q[`RFT_RX_TREXT], 2'b00, txo_q[1:0], 5'h00, 15'h0000};
        word_len = 6'd17;
        crc_cmd = rfid_tx_pkg::CRC_5;
      end
      `RFT_CMD_QUERYREP: begin
        word_cmd = {2'b00, txo_q[1:0], 28'h0000000};
        word_len = 6'd4;
      end
      `RFT_CMD_QUERYADJ: begin
        word_cmd = {4'b1001, txo_q[1:0], 3'b000, 23'h000000};
        word_len = 6'd9;
      end
      `RFT_CMD_ACK: begin
        word_cmd = {2'b01, hnd_hi_q, hnd_lo_q, 14'h0000};
        word_len = 6'd18;
      end
      `RFT_CMD_NAK: begin
        word_cmd = {8'b1100_0000, 24'h000000};
        word_len = 6'd8;
      end
      `RFT_CMD_REQRN: begin
        word_cmd = {8'b1100_0001, hnd_hi_q, hnd_lo_q, 8'h00};
        word_len = 6'd24;
        crc_cmd = rfid_tx_pkg::CRC_16;
      end
      default: ;
    endcase
  end

  assign fifo_bits = {1'b0, len1_q, len2_q[7:4], 3'b000} + {13'h0000, len2_q[0] ? len2_q[3:1] : 3'b000};
  assign start_word = cmd_wr && word_len != 6'd0 && gen2 && state_q == rfid_tx_pkg::ST_IDLE;
  assign start_fifo = armed_q && !dly_wait_q && cnt_q != 5'h00 && gen2 && state_q == rfid_tx_pkg::ST_IDLE;

  // Bit sequencing helpers
  assign sym_end = sym_q == 15'h0000;
  assign advance = sym_end && (state_q == rfid_tx_pkg::ST_PAYLOAD || state_q == rfid_tx_pkg::ST_WAIT_DATA
    || state_q == rfid_tx_pkg::ST_CALIBRATION_HIGH || (state_q == rfid_tx_pkg::ST_RTCAL && !query_q));
  assign have_bit = src_word_q || byte_bits_q != 4'h0 || cnt_q != 5'h00;
  assign pop = advance && bits_left_q != 16'h0000 && !src_word_q && byte_bits_q == 4'h0 && cnt_q != 5'h00;
  assign cur_bit = src_word_q ? word_q[31] : (byte_bits_q == 4'h0 ? fifo_mem[rp_q][7] : byte_q[7]);
  assign crc_bit = (crc_kind_q == rfid_tx_pkg::CRC_16) ? ~crc16_q[15] : crc5_q[4];
  assign next_bit = cur_bit;
  assign low_phase = state_q == rfid_tx_pkg::ST_DELIM || ({2'b00, sym_q} < {5'h00, pw_cyc}
    && state_q != rfid_tx_pkg::ST_IDLE && state_q != rfid_tx_pkg::ST_WAIT_DATA && state_q != rfid_tx_pkg::ST_TAIL);

  // Delayed transmission: armed by command, timed from the end of a reception
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      armed_q <= 1'b0;
      dly_wait_q <= 1'b0;
      timer_run_q <= 1'b0;
      timer_q <= 15'h0000;
    end else begin
      if (cmd_wr && (i_wdata & 8'hfc) == `RFT_CMD_TX_NOCRC) begin
        armed_q <= 1'b1;
        dly_wait_q <= i_wdata[1];
        timer_run_q <= 1'b0;
      end else if (start_fifo) begin
        armed_q <= 1'b0;
      end else if (dly_wait_q && !timer_run_q && i_rx_end) begin
        timer_run_q <= 1'b1;
        timer_q <= 15'(slot_q * 15'(`RFT_SLOT_UNIT_CYC));
      end else if (timer_run_q) begin
        if (timer_q == 15'h0000) begin
          timer_run_q <= 1'b0;
          dly_wait_q <= 1'b0;
        end else begin
          timer_q <= timer_q - 15'h0001;
        end
      end
    end
  end

  // Framer: delimiter, data-0, RTcal, Calibration_high for Query, payload, CRC, closing symbol
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_q <= rfid_tx_pkg::ST_IDLE;
      sym_q <= 15'h0000;
      src_word_q <= 1'b0;
      query_q <= 1'b0;
      crc_kind_q <= rfid_tx_pkg::CRC_NONE;
      word_q <= 32'h0000_0000;
      bits_left_q <= 16'h0000;
      byte_q <= 8'h00;
      byte_bits_q <= 4'h0;
      crc16_q <= `RFT_CRC16_PRESET;
      crc5_q <= `RFT_CRC5_PRESET;
      crc_left_q <= 5'h00;
      tx_mod_q <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      tx_mod_q <= ~low_phase;
      busy_q <= state_q != rfid_tx_pkg::ST_IDLE;
      if (start_word || start_fifo) begin
        state_q <= rfid_tx_pkg::ST_DELIM;
        sym_q <= 15'(`RFT_DELIM_CYC - 1);
        src_word_q <= start_word;
        query_q <= start_word && i_wdata == `RFT_CMD_QUERY;
        crc_kind_q <= start_word ? crc_cmd : (armed_q && len_crc_q ? rfid_tx_pkg::CRC_16 : rfid_tx_pkg::CRC_NONE);
        word_q <= word_cmd;
        bits_left_q <= start_word ? {10'h000, word_len} : fifo_bits;
        byte_bits_q <= 4'h0;
        crc16_q <= `RFT_CRC16_PRESET;
        crc5_q <= `RFT_CRC5_PRESET;
      end else if (!sym_end) begin
        sym_q <= sym_q - 15'h0001;
      end else begin
        unique case (state_q)
          rfid_tx_pkg::ST_IDLE: ;
          rfid_tx_pkg::ST_DELIM: begin
            state_q <= rfid_tx_pkg::ST_DATA0;
            sym_q <= 15'(d0_cyc - 12'd1);
          end
          rfid_tx_pkg::ST_DATA0: begin
            state_q <= rfid_tx_pkg::ST_RTCAL;
            sym_q <= 15'(rt_cyc - 13'd1);
          end
          rfid_tx_pkg::ST_RTCAL, rfid_tx_pkg::ST_CALIBRATION_HIGH, rfid_tx_pkg::ST_PAYLOAD, rfid_tx_pkg::ST_WAIT_DATA: begin
            if (state_q == rfid_tx_pkg::ST_RTCAL && query_q) begin
              state_q <= rfid_tx_pkg::ST_CALIBRATION_HIGH;
              sym_q <= tr_cyc - 15'h0001;
            end else if (bits_left_q != 16'h0000) begin
              if (have_bit) begin
                state_q <= rfid_tx_pkg::ST_PAYLOAD;
                sym_q <= 15'(next_bit ? d1_cyc - 12'd1 : d0_cyc - 12'd1);
                bits_left_q <= bits_left_q - 16'h0001;
                crc16_q <= {crc16_q[14:0], 1'b0} ^ ((crc16_q[15] ^ next_bit) ? `RFT_CRC16_POLY : 16'h0000);
                crc5_q <= {crc5_q[3:0], 1'b0} ^ ((crc5_q[4] ^ next_bit) ? `RFT_CRC5_POLY : 5'h00);
                word_q <= {word_q[30:0], 1'b0};
                if (pop) begin
                  byte_q <= {fifo_mem[rp_q][6:0], 1'b0};
                  byte_bits_q <= 4'h7;
                end else if (!src_word_q) begin
                  byte_q <= {byte_q[6:0], 1'b0};
                  byte_bits_q <= byte_bits_q - 4'h1;
                end
              end else begin
                state_q <= rfid_tx_pkg::ST_WAIT_DATA; // Underrun holds the carrier unmodulated
              end
            end else if (crc_kind_q != rfid_tx_pkg::CRC_NONE) begin
              state_q <= rfid_tx_pkg::ST_CRC;
              crc_left_q <= (crc_kind_q == rfid_tx_pkg::CRC_16) ? 5'd15 : 5'd4;
              sym_q <= 15'(crc_bit ? d1_cyc - 12'd1 : d0_cyc - 12'd1);
            end else begin
              state_q <= rfid_tx_pkg::ST_TAIL;
              sym_q <= 15'(d0_cyc - 12'd1);
            end
          end
          rfid_tx_pkg::ST_CRC: begin
            crc16_q <= {crc16_q[14:0], 1'b1};
            crc5_q <= {crc5_q[3:0], 1'b0};
            if (crc_left_q == 5'h00) begin
              state_q <= rfid_tx_pkg::ST_TAIL;
              sym_q <= 15'(d0_cyc - 12'd1);
            end else begin
              crc_left_q <= crc_left_q - 5'h01;
              sym_q <= 15'((crc_kind_q == rfid_tx_pkg::CRC_16 ? ~crc16_q[14] : crc5_q[3]) ? d1_cyc - 12'd1
                : d0_cyc - 12'd1);
            end
          end
          rfid_tx_pkg::ST_TAIL: state_q <= rfid_tx_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Remembers which transmit command armed the FIFO path
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      len_crc_q <= 1'b0;
    end else if (cmd_wr && (i_wdata & 8'hfc) == `RFT_CMD_TX_NOCRC) begin
      len_crc_q <= i_wdata[0];
    end
  end

  // Interrupt causes: an event in the clearing read's cycle survives
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      irq_q <= 8'h00;
      irq_out_q <= 1'b0;
    end else begin
      irq_q <= ((i_rd && i_addr == `RFT_A_IRQ) ? 8'h00 : irq_q)
        | (8'(pop && !push && cnt_q == `RFT_FIFO_LOW_MARK + 5'd1) << `RFT_IRQ_FIFO_LOW)
        | (8'(state_q == rfid_tx_pkg::ST_TAIL && sym_end) << `RFT_IRQ_TX_END);
      irq_out_q <= irq_q != 8'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst || !i_rd) begin
      rdata_q <= 8'h00;
    end else begin
      unique case (i_addr)
        `RFT_A_CHIP_CTRL: rdata_q <= ctrl_q;
        `RFT_A_PROTOCOL: rdata_q <= prot_q;
        `RFT_A_TX_OPT: rdata_q <= txo_q;
        `RFT_A_RX_OPT: rdata_q <= rxo_q;
        `RFT_A_CAL_LO: rdata_q <= cal_lo_q;
        `RFT_A_CAL_HI: rdata_q <= cal_hi_q;
        `RFT_A_SLOT: rdata_q <= slot_q;
        `RFT_A_IRQ: rdata_q <= irq_q;
        `RFT_A_STATUS: rdata_q <= (8'(settled_q) << `RFT_ST_SETTLED) | (8'(busy_q) << `RFT_ST_BUSY);
        `RFT_A_MODSET: rdata_q <= modset_q;
        `RFT_A_LEN1: rdata_q <= len1_q;
        `RFT_A_LEN2: rdata_q <= len2_q;
        `RFT_A_HANDLE_HI: rdata_q <= hnd_hi_q;
        `RFT_A_HANDLE_LO: rdata_q <= hnd_lo_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign o_rdata = rdata_q;
  assign o_irq = irq_out_q;
  assign o_modulation = tx_mod_q;
  assign o_tx_on = ctrl_q[`RFT_CC_CARRIER];
  assign o_rx_section_on = ctrl_q[`RFT_CC_CARRIER];
  assign o_receiver_on = ctrl_q[`RFT_CC_RECEIVER];
  assign o_gain_ctrl_on = ctrl_q[`RFT_CC_GAIN_CTRL];
  assign o_gain_level_on = ctrl_q[`RFT_CC_GAIN_LEVEL];
  assign o_dac_on = ctrl_q[`RFT_CC_DAC];
  assign o_direct_mode = ctrl_q[`RFT_CC_DIRECT];
  assign o_standby = ctrl_q[`RFT_CC_STANDBY];
  assign o_field_on = field_q;
  assign o_carrier_settled = settled_q;
  assign o_rx_crc_skip = prot_q[`RFT_PS_CRC_SKIP];
  assign o_rx_coding = prot_q[4:3];
  assign o_tx_busy = busy_q;
endmodule : rfid_reader_transmit_control

// ==== tb/rfid_tx_checker.sv ====
// Port assertions for the transmit control block
`timescale 1ns/10ps
module rfid_tx_checker (
  input wire logic i_clk, i_nrst, i_en, i_wr, i_rd, o_irq, o_modulation, o_tx_busy, // Control and status
  input wire logic [7:0] i_addr, i_wdata, o_rdata, // Register port
  input wire logic o_tx_on, o_rx_section_on, o_receiver_on, o_gain_ctrl_on, o_gain_level_on, // Main control
  input wire logic o_dac_on, o_direct_mode, o_standby, o_field_on, o_carrier_settled, o_rx_crc_skip, // More
  input wire logic [1:0] o_rx_coding // Receive coding
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_carrier_both: assert property (o_tx_on == o_rx_section_on) else $error("carrier sections differ");
  a_main_bits: assert property (i_wr && i_addr == 8'h00 |=> {o_standby, o_direct_mode, o_dac_on,
    o_gain_level_on, o_gain_ctrl_on, o_receiver_on, o_tx_on} == $past(i_wdata[6:0])) else $error("main bits");
  a_proto_fields: assert property (i_wr && i_addr == 8'h01 && !(i_en && !$past(i_en)) |=>
    {o_rx_crc_skip, o_rx_coding} == {$past(i_wdata[7]), $past(i_wdata[4:3])}) else $error("protocol fields");
  a_settled_field: assert property (o_carrier_settled |-> o_field_on) else $error("settled without field");
  a_settled_drop: assert property ($fell(o_tx_on) |-> ##[0:2] !o_carrier_settled) else $error("settled stuck");
  a_status_read: assert property (i_rd && i_addr == 8'h0e |=> o_rdata[0] == $past(o_carrier_settled))
    else $error("status settled bit");
  a_busy_mod: assert property ($fell(o_modulation) |-> ##[0:2] o_tx_busy) else $error("pulse while idle");
  a_end_irq: assert property ($fell(o_tx_busy) |-> ##[0:3] o_irq) else $error("no end interrupt");
endmodule : rfid_tx_checker
bind rfid_reader_transmit_control rfid_tx_checker u_rfid_tx_checker (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_en(i_en), .i_wr(i_wr), .i_rd(i_rd), .o_irq(o_irq),
  .o_modulation(o_modulation), .o_tx_busy(o_tx_busy), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
  .o_tx_on(o_tx_on), .o_rx_section_on(o_rx_section_on), .o_receiver_on(o_receiver_on),
  .o_gain_ctrl_on(o_gain_ctrl_on), .o_gain_level_on(o_gain_level_on), .o_dac_on(o_dac_on),
  .o_direct_mode(o_direct_mode), .o_standby(o_standby), .o_field_on(o_field_on),
  .o_carrier_settled(o_carrier_settled), .o_rx_crc_skip(o_rx_crc_skip), .o_rx_coding(o_rx_coding));

// ==== tb/host_bus_model.sv ====
// Host microcontroller model on the register port
`timescale 1ns/10ps
module host_bus_model (
  input wire logic i_clk, // Clock
  input wire logic [7:0] i_rdata, // Read data from the block
  output logic [7:0] o_addr, // Address
  output logic [7:0] o_wdata, // Write data
  output logic o_wr, // Write strobe
  output logic o_rd, // Read strobe
  output logic o_en // Chip enable pin
);
  initial {o_addr, o_wdata, o_wr, o_rd, o_en} = '0;
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    {o_wr, o_addr, o_wdata} <= {1'b1, a, d};
    @(posedge i_clk);
    o_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    {o_rd, o_addr} <= {1'b1, a};
    @(posedge i_clk);
    o_rd <= 1'b0;
    @(negedge i_clk);
    d = i_rdata;
  endtask : rd
  // Command, length, then data; a few bytes only, so the FIFO never overflows
  task send(input logic [7:0] cmd, input logic [3:0] n);
    wr(8'h20, cmd);
    wr(8'h1d, 8'h00);
    wr(8'h1e, {n, 4'h0});
    for (int i = 0; i < n; i++) wr(8'h1f, 8'ha5 ^ 8'(i));
  endtask : send
  task en_cycle;
    @(posedge i_clk);
    o_en <= 1'b0;
    repeat (2) @(posedge i_clk);
    o_en <= 1'b1;
    repeat (2) @(posedge i_clk);
  endtask : en_cycle
endmodule : host_bus_model

// ==== tb/rfid_reader_transmit_control_tb_top.sv ====
// Self-checking bench for the transmit control block
`timescale 1ns/10ps
module rfid_reader_transmit_control_tb_top;
  logic i_clk = 1'b0, i_nrst = 1'b0, i_en, i_wr, i_rd, i_rx_end = 1'b0, o_irq, o_modulation, o_tx_busy;
  logic [7:0] i_addr, i_wdata, o_rdata, d;
  logic o_tx_on, o_rx_section_on, o_receiver_on, o_gain_ctrl_on, o_gain_level_on, o_dac_on, o_direct_mode;
  logic o_standby, o_field_on, o_carrier_settled, o_rx_crc_skip;
  logic [1:0] o_rx_coding;
  int error_cnt = 0, checked = 0;
  always #12.5 i_clk = ~i_clk;
  rfid_reader_transmit_control #(.RAMP_200_CYC(15'd20), .RAMP_400_CYC(15'd40)) u_rfid_reader_transmit_control (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_en(i_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_rx_end(i_rx_end), .o_rdata(o_rdata), .o_irq(o_irq), .o_modulation(o_modulation), .o_tx_on(o_tx_on),
    .o_rx_section_on(o_rx_section_on), .o_receiver_on(o_receiver_on), .o_gain_ctrl_on(o_gain_ctrl_on),
    .o_gain_level_on(o_gain_level_on), .o_dac_on(o_dac_on), .o_direct_mode(o_direct_mode), .o_standby(o_standby),
    .o_field_on(o_field_on), .o_carrier_settled(o_carrier_settled), .o_rx_crc_skip(o_rx_crc_skip),
    .o_rx_coding(o_rx_coding), .o_tx_busy(o_tx_busy));
  host_bus_model u_host_bus_model (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr(i_wr), .o_rd(i_rd), .o_en(i_en));
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Kind 0 modulation, 1 carrier settled, 2 interrupt
  task waitfor(input int k, input logic lvl, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      if ((k == 0 ? o_modulation : k == 1 ? o_carrier_settled : o_irq) === lvl) break;
      @(negedge i_clk);
    end
    chk("wait bound", 8'h00, 8'(n == lim));
    if (n == lim) conclude();
  endtask : waitfor
  task conclude;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task t_preset;
    logic [7:0] pre [5];
    pre = '{8'h02, 8'hf0, 8'h61, 8'h35, 8'h05};
    for (int a = 1; a < 6; a++) begin
      u_host_bus_model.rd(8'(a), d);
      chk("preset", pre[a-1], d);
    end
    u_host_bus_model.rd(8'h7f, d);
    chk("unmapped", 8'h00, d);
    u_host_bus_model.wr(8'h01, 8'h98);
    @(negedge i_clk);
    chk("crc skip and coding", 8'h07, {5'h00, o_rx_crc_skip, o_rx_coding});
    u_host_bus_model.en_cycle();
    u_host_bus_model.rd(8'h01, d);
    chk("preset again", 8'h02, d);
    u_host_bus_model.wr(8'h01, 8'h00);
    $display("preset test done");
  endtask : t_preset
  task t_carrier;
    u_host_bus_model.wr(8'h15, 8'h02);
    u_host_bus_model.wr(8'h00, 8'h7e);
    @(negedge i_clk);
    chk("main bits", 8'h7e, {1'b0, o_standby, o_direct_mode, o_dac_on, o_gain_level_on, o_gain_ctrl_on,
      o_receiver_on, o_tx_on});
    u_host_bus_model.wr(8'h00, 8'h01);
    @(negedge i_clk);
    chk("sections on", 8'h03, {6'h00, o_tx_on, o_rx_section_on});
    repeat (15) @(negedge i_clk);
    chk("still ramping", 8'h00, {7'h00, o_carrier_settled});
    waitfor(1, 1'b1, 20);
    u_host_bus_model.rd(8'h0e, d);
    chk("settled bit", 8'h01, d & 8'h01);
    u_host_bus_model.wr(8'h00, 8'h00);
    @(negedge i_clk);
    chk("ramp down", 8'h01, {7'h00, o_field_on});
    repeat (10) @(negedge i_clk);
    chk("ramping down", 8'h01, {7'h00, o_field_on});
    repeat (15) @(negedge i_clk);
    chk("field off", 8'h00, {7'h00, o_field_on});
    $display("carrier test done");
  endtask : t_carrier
  task t_frame;
    u_host_bus_model.send(8'h90, 4'd5);
    waitfor(0, 1'b0, 20);
    waitfor(2, 1'b1, 30000);
    u_host_bus_model.rd(8'h0c, d);
    chk("low fifo cause", 8'h20, d);
    @(posedge i_clk);
    @(negedge i_clk);
    chk("irq cleared", 8'h00, {7'h00, o_irq});
    waitfor(2, 1'b1, 30000);
    u_host_bus_model.rd(8'h0c, d);
    chk("end cause", 8'h80, d);
    u_host_bus_model.wr(8'h20, 8'h98);
    waitfor(0, 1'b0, 6);
    waitfor(2, 1'b1, 30000);
    u_host_bus_model.rd(8'h0c, d);
    chk("query end", 8'h80, d);
    $display("frame test done");
  endtask : t_frame
  // Slot delay of 2 us is 80 cycles; the frame must wait for the end of a reception
  task t_delay;
    u_host_bus_model.wr(8'h06, 8'h02);
    u_host_bus_model.send(8'h93, 4'd1);
    u_host_bus_model.rd(8'h1e, d);
    chk("length pair", 8'h10, d);
    repeat (20) @(negedge i_clk);
    chk("delay holds", 8'h00, {7'h00, o_tx_busy});
    @(posedge i_clk);
    i_rx_end <= 1'b1;
    @(posedge i_clk);
    i_rx_end <= 1'b0;
    repeat (78) @(negedge i_clk);
    chk("slot wait", 8'h01, {7'h00, o_modulation});
    waitfor(0, 1'b0, 10);
    waitfor(2, 1'b1, 30000);
    u_host_bus_model.rd(8'h0c, d);
    chk("delayed end", 8'h80, d);
    $display("delay test done");
  endtask : t_delay
  initial begin
    repeat (12) @(posedge i_clk);
    i_nrst <= 1'b1;
    u_host_bus_model.en_cycle();
    t_preset();
    t_carrier();
    t_frame();
    t_delay();
    conclude();
  end
endmodule : rfid_reader_transmit_control_tb_top
